/* File: src/rcg_top.sv */
// Output clock generator with sleep handling, clock tail and reset routing
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps

// Functional notes
// - Divide crystal clock, drive output pin
// - Three-bit select picks one of eight rates
// - Lowest rate comes from low-frequency clock
// - Reset gives 1 MHz, register 06h
// - Sleep with low-frequency enable outputs slow clock
// - Awake states output selected rate; selects 0 to 4 all give 5 MHz, select 5 gives 2.5 MHz
// - Crystal disabled while sleeping
// - Without low-frequency enable, stop clock in sleep
// - Tail field adds 0/128/256/512 cycles first
// - Pending interrupt keeps output clock running
// - Sleep taken only after interrupt read
// - Software reset pulse 50 to 470 us
// - Any reset restores register defaults
// - Reset on pin 0, inverse pin 1
module rcg_top
   import rcg_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // Register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic [7:0]      rdata,
   // Radio state machine interface
   input  wire logic       sleep_req,
   input  wire logic       irq_pending,
   input  wire logic       soft_reset_req,
   output logic            xtal_enable,
   output logic            core_reset,
   // Pins
   input  wire logic       lf_clk_pin,
   output logic            clk_out,
   output logic            gpio0_reset,
   output logic            gpio1_reset_n
);

   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] rdata;
      logic       out;
      logic       src_lf;
      logic [9:0] tail_cnt;
      rcg_state_t st;
      logic       lf_meta;
      logic       lf_sync;
      logic       rst_out;
      logic       xtal_en;
   } rcg_top_state_t;

   localparam rcg_top_state_t RESET_STATE = '{
      ctl:      CTL_RESET,
      rdata:    8'h00,
      out:      1'b0,
      src_lf:   1'b0,
      tail_cnt: 10'h000,
      st:       st_run,
      lf_meta:  1'b0,
      lf_sync:  1'b0,
      rst_out:  1'b1,
      xtal_en:  1'b1
   };

   rcg_top_state_t r;
   rcg_top_state_t n;

   logic       swrst_active;
   logic       rst;
   logic       div_tick;
   logic [2:0] sel;
   logic       lfc_en;
   logic [1:0] tail_code;
   logic [9:0] target;
   logic       eff_sleep;
   logic       want_lf;
   logic       rise;
   logic [7:0] status;

   // Stretched software reset; it must survive its own effect so it runs on resetn only
   rcg_soft_reset u_swrst (
      .clock  (clock),
      .resetn (resetn),
      .start  (soft_reset_req),
      .active (swrst_active)
   );

   // Either reset source reloads the state register and the divider; the stretcher sees resetn only
   assign rst = !resetn || swrst_active;

   // Field decode of the control register
   assign sel       = r.ctl[SEL_LSB +: 3];
   assign lfc_en    = r.ctl[LFC_BIT];
   assign tail_code = r.ctl[TAIL_LSB +: 2];
   assign target    = tail_target(tail_code);

   // Rate enable derived from the system clock standing in for the crystal
   rcg_rate_div u_div (
      .clock  (clock),
      .resetn (!rst),
      .sel    (sel),
      .tick   (div_tick)
   );

   // Sleep is held off while an interrupt is unread
   assign eff_sleep = sleep_req && !irq_pending;

   // Slow source for the lowest rate, or for any rate while asleep with the enable set
   assign want_lf = (sel == SEL_LF) || (eff_sleep && lfc_en);

   // Status byte
   always_comb begin
      status = 8'h00;
      status[ST_OUT_BIT]  = r.out;
      status[ST_SRC_BIT]  = r.src_lf;
      status[ST_TAIL_BIT] = (r.st == st_tail);
      status[ST_OFF_BIT]  = (r.st == st_off);
      status[ST_XTAL_BIT] = r.xtal_en;
      status[ST_SLP_BIT]  = eff_sleep;
   end

   // Next state: synchroniser, clock generation, sleep sequencing and registers
   always_comb begin
      n    = r;
      rise = 1'b0;
      // Two stage synchroniser for the slow clock pin
      n.lf_meta = lf_clk_pin;
      n.lf_sync = r.lf_meta;
      n.rst_out = 1'b0;
      case (r.st)
         st_run, st_tail: begin
            // Source changes only while the pin is low, so no pulse is ever cut short
            if (!r.out && (r.src_lf != want_lf)) begin
               n.src_lf = want_lf;
            end else if (r.src_lf) begin
               n.out = r.lf_sync;
            end else if (div_tick) begin
               n.out = !r.out;
            end
            rise = n.out && !r.out;
            if (r.st == st_run) begin
               if (eff_sleep && !lfc_en) begin
                  n.st       = st_tail;
                  n.tail_cnt = 10'h000;
               end
            end else if (!eff_sleep || lfc_en) begin
               n.st = st_run;
            end else if ((r.tail_cnt == target) && !r.out) begin
               // Stop at a low phase once the tail is used up
               n.st  = st_off;
               n.out = 1'b0;
            end else if (rise) begin
               n.tail_cnt = r.tail_cnt + 10'h001;
            end
         end
         st_off: begin
            n.out = 1'b0;
            if (!eff_sleep || lfc_en) begin
               n.st = st_run;
            end
         end
         default: begin
            n.st  = st_run;
            n.out = 1'b0;
         end
      endcase
      // Crystal stops once sleeping and the output no longer needs it
      n.xtal_en = !(eff_sleep && ((n.st == st_off) || (lfc_en && n.src_lf)));
      // Register write; upper bits are not stored
      if (wr && (addr == ADDR_OUT_CLK)) begin
         n.ctl = wdata & CTL_MASK;
      end
      // Read data stand for one cycle only
      n.rdata = 8'h00;
      if (rd) begin
         case (addr)
            ADDR_OUT_CLK: n.rdata = r.ctl;
            ADDR_STATUS:  n.rdata = status;
            default:      n.rdata = 8'h00;
         endcase
      end
   end

   // State register; defaults come back on any reset
   always_ff @(posedge clock) begin
      if (rst) begin
         r <= RESET_STATE;
      end else begin
         r <= n;
      end
   end

   // Outputs from flip-flops; reset pins show the internal reset one cycle late
   assign rdata         = r.rdata;
   assign clk_out       = r.out;
   assign xtal_enable   = r.xtal_en;
   assign core_reset    = r.rst_out;
   assign gpio0_reset   = r.rst_out;
   assign gpio1_reset_n = !r.rst_out;

   a_reset_default: assert property (@(posedge clock)
      $past(rst) |-> (r.ctl == CTL_RESET && r.st == st_run))
      else $error("control register not at default after reset");

   a_gpio_pair: assert property (@(posedge clock)
      $past(rst) |-> (gpio0_reset && !gpio1_reset_n))
      else $error("reset not routed to pins");

   a_irq_holds: assert property (@(posedge clock) disable iff (rst)
      (irq_pending && $past(irq_pending) && $past(r.st) != st_off) |-> (r.st != st_off && xtal_enable))
      else $error("clock stopped with interrupt pending");

   a_off_low: assert property (@(posedge clock) disable iff (rst)
      (r.st == st_off) |-> (!clk_out && !xtal_enable && eff_sleep) or (!eff_sleep || lfc_en))
      else $error("output not stopped in sleep");

   a_switch_low: assert property (@(posedge clock) disable iff (rst)
      (r.src_lf != $past(r.src_lf)) |-> !$past(r.out))
      else $error("source switched during high phase");

   a_lf_follow: assert property (@(posedge clock) disable iff (rst)
      (r.src_lf && r.st != st_off && (r.src_lf == want_lf)
       && !(r.st == st_tail && r.tail_cnt == target)) |=> (r.out == $past(r.lf_sync)))
      else $error("slow clock not passed through");

   a_tail_bound: assert property (@(posedge clock) disable iff (rst)
      (r.st == st_tail) |-> (r.tail_cnt <= target))
      else $error("tail count overran");

   a_tail_zero: assert property (@(posedge clock) disable iff (rst)
      (r.st == st_tail && target == 10'h000 && !r.out && eff_sleep && !lfc_en
       && $stable(r.ctl)) |=> (r.st == st_off))
      else $error("zero tail did not stop at once");

   a_rdata_pulse: assert property (@(posedge clock) disable iff (rst)
      !$past(rd) |-> (rdata == 8'h00))
      else $error("read data outside read slot");

   c_tail_off:  cover property (@(posedge clock) disable iff (rst)
      (r.st == st_tail) ##1 (r.st == st_off));
   c_lf_sleep:  cover property (@(posedge clock) disable iff (rst)
      eff_sleep && lfc_en && r.src_lf && clk_out);
   c_irq_hold:  cover property (@(posedge clock) disable iff (rst)
      sleep_req && irq_pending && clk_out);
   c_swrst:     cover property (@(posedge clock) $rose(swrst_active));

endmodule

/* File: inc/rcg_pkg.sv */
// Shared constants, register map and helpers for the radio output clock block
package rcg_pkg;

   // System clock rate
   localparam int CLK_HZ = 10_000_000;

   // Register map (byte addresses on the plain register port)
   localparam logic [7:0] ADDR_OUT_CLK = 8'h0A;
   localparam logic [7:0] ADDR_STATUS  = 8'h0B;

   // Output clock control layout
   localparam logic [7:0] CTL_RESET  = 8'h06;
   localparam logic [7:0] CTL_MASK   = 8'h3F;
   localparam int         SEL_LSB    = 0;
   localparam int         LFC_BIT    = 3;
   localparam int         TAIL_LSB   = 4;
   localparam logic [2:0] SEL_LF     = 3'h7;

   // Status register layout
   localparam int ST_OUT_BIT  = 0;
   localparam int ST_SRC_BIT  = 1;
   localparam int ST_TAIL_BIT = 2;
   localparam int ST_OFF_BIT  = 3;
   localparam int ST_XTAL_BIT = 4;
   localparam int ST_SLP_BIT  = 5;

   // Output rates in Hz for each divide select code
   localparam int RATE_0_HZ = 30_000_000;
   localparam int RATE_1_HZ = 15_000_000;
   localparam int RATE_2_HZ = 10_000_000;
   localparam int RATE_3_HZ = 4_000_000;
   localparam int RATE_4_HZ = 3_000_000;
   localparam int RATE_5_HZ = 2_000_000;
   localparam int RATE_6_HZ = 1_000_000;
   localparam int RATE_7_HZ = 32_768;

   // Tail lengths in output clock cycles
   localparam logic [9:0] TAIL_0 = 10'h000;
   localparam logic [9:0] TAIL_1 = 10'h080;
   localparam logic [9:0] TAIL_2 = 10'h100;
   localparam logic [9:0] TAIL_3 = 10'h200;

   // Divider half period counter width
   localparam int HALF_W = 3;

   // Software reset pulse: chosen inside the allowed 50..470 us window
   localparam int SOFT_RESET_PULSE_TIME_US = 100;
   localparam int SOFT_RESET_CYCLES = (SOFT_RESET_PULSE_TIME_US * (CLK_HZ / 1_000_000));
   localparam int SWRST_W = 11;

   // Output states
   typedef enum logic [1:0] {st_run, st_tail, st_off} rcg_state_t;

   // Rate of a divide select code
   function automatic int rate_hz(input logic [2:0] sel);
      case (sel)
         3'h0:    rate_hz = RATE_0_HZ;
         3'h1:    rate_hz = RATE_1_HZ;
         3'h2:    rate_hz = RATE_2_HZ;
         3'h3:    rate_hz = RATE_3_HZ;
         3'h4:    rate_hz = RATE_4_HZ;
         3'h5:    rate_hz = RATE_5_HZ;
         3'h6:    rate_hz = RATE_6_HZ;
         default: rate_hz = RATE_7_HZ;
      endcase
   endfunction

   // Half period in system cycles, never below one
   function automatic logic [HALF_W-1:0] half_count(input logic [2:0] sel);
      int h;
      h = CLK_HZ / (2 * rate_hz(sel));
      if (h < 1) begin
         h = 1;
      end
      if (h > (2 ** HALF_W) - 1) begin
         h = (2 ** HALF_W) - 1;
      end
      half_count = h[HALF_W-1:0];
   endfunction

   // Extra output cycles before shut off
   function automatic logic [9:0] tail_target(input logic [1:0] code);
      case (code)
         2'h0:    tail_target = TAIL_0;
         2'h1:    tail_target = TAIL_1;
         2'h2:    tail_target = TAIL_2;
         default: tail_target = TAIL_3;
      endcase
   endfunction

endpackage

/* File: src/rcg_rate_div.sv */
// Divider that gives one enable pulse per half period of the selected output rate
`timescale 1ns/100ps
module rcg_rate_div
   import rcg_pkg::*;
(
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       resetn,
   // Rate select and half period tick
   input  wire logic [2:0] sel,
   output logic            tick
);

   typedef struct packed {
      logic [HALF_W-1:0] cnt;
   } rcg_div_state_t;

   rcg_div_state_t r;
   rcg_div_state_t n;

   // Count down, reload from the current select so a rate change lands at a half period
   always_comb begin
      n = r;
      tick = (r.cnt == '0);
      if (tick) begin
         n.cnt = half_count(sel) - {{(HALF_W-1){1'b0}}, 1'b1};
      end else begin
         n.cnt = r.cnt - {{(HALF_W-1){1'b0}}, 1'b1};
      end
   end

   // State register
   always_ff @(posedge clock) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   a_div_period: assert property (@(posedge clock) disable iff (!resetn)
      (tick && $stable(sel) && half_count(sel) == 3'h5) |=> !tick [*4] ##1 tick)
      else $error("divider half period wrong");

endmodule

/* File: src/rcg_soft_reset.sv */
// Stretches a software reset request into a fixed length internal reset pulse
`timescale 1ns/100ps
module rcg_soft_reset
   import rcg_pkg::*;
(
   // Clock and reset
   input  wire logic clock,
   input  wire logic resetn,
   // Request and stretched pulse
   input  wire logic start,
   output logic      active
);

   localparam logic [SWRST_W-1:0] LAST = SWRST_W'(SOFT_RESET_CYCLES - 1);

   typedef struct packed {
      logic               busy;
      logic [SWRST_W-1:0] cnt;
   } rcg_swr_state_t;

   rcg_swr_state_t r;
   rcg_swr_state_t n;

   // A request during the pulse is absorbed; the pulse length stays fixed
   always_comb begin
      n = r;
      if (!r.busy) begin
         if (start) begin
            n.busy = 1'b1;
            n.cnt  = '0;
         end
      end else if (r.cnt == LAST) begin
         n.busy = 1'b0;
      end else begin
         n.cnt = r.cnt + {{(SWRST_W-1){1'b0}}, 1'b1};
      end
   end

   assign active = r.busy;

   // State register
   always_ff @(posedge clock) begin
      if (!resetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   a_swrst_hold: assert property (@(posedge clock) disable iff (!resetn)
      $rose(active) |-> active [*8])
      else $error("soft reset pulse too short");

   a_swrst_bound: assert property (@(posedge clock) disable iff (!resetn)
      active |-> (r.cnt <= LAST))
      else $error("soft reset pulse too long");

   c_swrst_end: cover property (@(posedge clock) disable iff (!resetn) $fell(active));

endmodule

/* File: dv/rcg_host_model.sv */
// Host side model: counts output clock rises and measures their spacing
`timescale 1ns/100ps
module rcg_host_model (
   // Clock and pins seen by the host
   input  wire logic        clock,
   input  wire logic        clk_out,
   input  wire logic        gpio0_reset,
   input  wire logic        gpio1_reset_n,
   // Bench control and results
   input  wire logic        clear,
   output logic [15:0]      n_rise,
   output logic [15:0]      period,
   output logic             host_in_reset
);
   logic        prev_reg;
   logic [15:0] gap_reg;

   // Host reset input takes both pins; it is only asserted when both agree
   assign host_in_reset = gpio0_reset & ~gpio1_reset_n;

   // Edge counter and period meter, sampled on the system clock
   always_ff @(posedge clock) begin
      prev_reg <= clk_out;
      gap_reg  <= gap_reg + 16'h0001;
      if (clear) begin
         n_rise  <= 16'h0000;
         period  <= 16'h0000;
         gap_reg <= 16'h0000;
      end else if (clk_out && !prev_reg) begin
         n_rise  <= n_rise + 16'h0001;
         period  <= gap_reg + 16'h0001; // Spacing from previous rise
         gap_reg <= 16'h0000;
      end
   end
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the radio output clock block
`timescale 1ns/100ps
module tb;
   import rcg_pkg::*;
   logic        clock;
   logic        resetn;
   logic [7:0]  addr;
   logic [7:0]  wdata;
   logic        wr;
   logic        rd;
   logic [7:0]  rdata;
   logic        sleep_req;
   logic        irq_pending;
   logic        soft_reset_req;
   logic        xtal_enable;
   logic        core_reset;
   logic        lf_clk;
   logic        clk_out;
   logic        gpio0_reset;
   logic        gpio1_reset_n;
   logic        clear;
   logic [15:0] n_rise;
   logic [15:0] period;
   logic        rd_d;
   logic [15:0] held;
   logic [7:0]  d;
   logic [7:0]  exp_q[$];
   logic [15:0] per_tab[7] = '{16'h0002, 16'h0002, 16'h0002, 16'h0002,
                               16'h0002, 16'h0004, 16'h000A};
   int          n_errors;
   int          checks_done;
   int          cyc;
   int          k;

   rcg_top u_dut (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .sleep_req(sleep_req), .irq_pending(irq_pending),
      .soft_reset_req(soft_reset_req), .xtal_enable(xtal_enable), .core_reset(core_reset),
      .lf_clk_pin(lf_clk), .clk_out(clk_out), .gpio0_reset(gpio0_reset),
      .gpio1_reset_n(gpio1_reset_n));

   rcg_host_model u_host (.clock(clock), .clk_out(clk_out), .gpio0_reset(gpio0_reset),
      .gpio1_reset_n(gpio1_reset_n), .clear(clear), .n_rise(n_rise), .period(period),
      .host_in_reset());

   // System clock, and a slow clock of unrelated phase
   always #50 clock = ~clock;
   always #15259 lf_clk = ~lf_clk;

   task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clock);
      wr    <= 1'b0;
   endtask

   // Read data is judged by the monitor one cycle later
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clock);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock);
      rd   <= 1'b0;
   endtask

   task automatic pulse_clear();
      @(posedge clock);
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
   endtask

   // Stop right after a rise so the running high phase is never counted
   task automatic wait_rise();
      logic p;
      p = 1'b1;
      for (int i = 0; i < 800; i++) begin
         @(posedge clock);
         if (clk_out === 1'b1 && p === 1'b0) break;
         p = clk_out;
      end
   endtask

   // Read data monitor
   always @(posedge clock) begin
      rd_d <= rd;
      if (rd_d === 1'b1) begin
         check_val({8'h00, rdata}, {8'h00, exp_q.pop_front()});
      end
   end

   // Hang guard
   always @(posedge clock) begin
      cyc++;
      if (cyc == 40000) begin
         n_errors++;
         report_and_stop();
      end
   end

   initial begin
      clock = 1'b0;
      lf_clk = 1'b0;
      {resetn, wr, rd, sleep_req, irq_pending, soft_reset_req} = 6'h00;
      addr = 8'h00;
      wdata = 8'h00;
      clear = 1'b1;
      k = $urandom(32'hA097CEA7);
      cycles(10);
      check_val({14'h0000, gpio0_reset, gpio1_reset_n}, 16'h0002);
      resetn <= 1'b1;
      clear  <= 1'b0;
      cycles(3);
      check_val({14'h0000, gpio0_reset, gpio1_reset_n}, 16'h0001);
      rd_reg(ADDR_OUT_CLK, 8'h06);
      cycles(30);
      check_val(period, 16'h000A);
      // Readback with random data, upper bits dropped, unmapped place
      for (int i = 0; i < 4; i++) begin
         // Select kept off the slow source so the rate sweep that follows starts at once
         d = 8'($urandom) & 8'hFB;
         wr_reg(ADDR_OUT_CLK, d);
         rd_reg(ADDR_OUT_CLK, d & 8'h3F);
      end
      wr_reg(8'h55, d);
      rd_reg(8'h55, 8'h00);
      // Every divided rate while awake
      for (int s = 0; s < 7; s++) begin
         wr_reg(ADDR_OUT_CLK, 8'(s));
         cycles(40);
         check_val(period, per_tab[s]);
         check_val({15'h0000, xtal_enable}, 16'h0001);
      end
      wr_reg(ADDR_OUT_CLK, 8'h07);
      cycles(700);
      check_val(16'(period >= 16'h0130 && period <= 16'h0133), 16'h0001);
      // Every tail length before shut off
      for (int t = 0; t < 4; t++) begin
         wr_reg(ADDR_OUT_CLK, 8'(t * 16 + 5));
         cycles(10);
         wait_rise();
         sleep_req <= 1'b1;
         clear     <= 1'b1;
         @(posedge clock);
         clear <= 1'b0;
         for (int i = 0; i < 6000 && xtal_enable !== 1'b0; i++) @(posedge clock);
         held = n_rise;
         check_val(held, (t == 0) ? 16'h0000 : (16'h0040 << t));
         check_val({15'h0000, xtal_enable}, 16'h0000);
         rd_reg(ADDR_STATUS, 8'h28);
         cycles(50);
         check_val(n_rise, held);
         sleep_req <= 1'b0;
         cycles(20);
      end
      // Slow clock kept through sleep even with select 0
      wr_reg(ADDR_OUT_CLK, 8'h08);
      sleep_req <= 1'b1;
      cycles(800);
      check_val(16'(period >= 16'h0130 && period <= 16'h0133), 16'h0001);
      check_val({15'h0000, xtal_enable}, 16'h0000);
      sleep_req <= 1'b0;
      // Pending interrupt holds the clock until read
      wr_reg(ADDR_OUT_CLK, 8'h06);
      irq_pending <= 1'b1;
      sleep_req   <= 1'b1;
      cycles(20);
      pulse_clear();
      cycles(100);
      check_val(16'(n_rise >= 16'h0009 && n_rise <= 16'h000B), 16'h0001);
      check_val({15'h0000, xtal_enable}, 16'h0001);
      irq_pending <= 1'b0;
      cycles(30);
      check_val({15'h0000, xtal_enable}, 16'h0000);
      sleep_req <= 1'b0;
      // Software reset stretches to a legal pulse and restores defaults
      wr_reg(ADDR_OUT_CLK, 8'h3F);
      @(posedge clock);
      soft_reset_req <= 1'b1;
      @(posedge clock);
      soft_reset_req <= 1'b0;
      cycles(3);
      check_val({14'h0000, gpio0_reset, gpio1_reset_n}, 16'h0002);
      k = 3;
      while (core_reset === 1'b1 && k < 6000) begin
         @(posedge clock);
         k++;
      end
      check_val(16'(k >= 500 && k <= 4700), 16'h0001);
      cycles(2);
      rd_reg(ADDR_OUT_CLK, 8'h06);
      cycles(5);
      report_and_stop();
   end
endmodule
